//--- verilog/nv_access_map.vh
// register offsets, field positions, key and command codes and timing counts
// for the protected configuration and nonvolatile access block
// assumes a byte-wide special function register bus with 8-bit offsets
`ifndef NV_ACCESS_MAP_VH
`define NV_ACCESS_MAP_VH

`define ADDR_NV_ADDRESS_LOW 8'h84
`define ADDR_NV_ADDRESS_HIGH 8'h85
`define ADDR_NV_RESULT 8'h86
`define ADDR_NV_DATA_LOW 8'h8E
`define ADDR_NV_DATA_HIGH 8'h8F
`define ADDR_SYSTEM_CONFIG 8'hB1
`define ADDR_PART_IDENTITY 8'hA1

`define UNLOCK_KEY_FIRST 8'h55
`define UNLOCK_KEY_SECOND 8'hAA
`define CMD_WRITE 8'h9A
`define CMD_READ_DATA 8'h8E

`define CFG_WDOG_BIT 0
`define CFG_REG_OFF_BIT 1
`define CFG_DATA_WE_BIT 2
`define CFG_CODE_WE_BIT 3
`define CFG_SOFT_RST_BIT 4
`define CFG_BOOT_BIT 5
`define RES_ADDR_OK_BIT 6
`define RES_CMD_FAULT_BIT 1

`define CW_READOUT_BIT 15
`define CW_BOOT_SEL_BIT 14
`define CW_LONG_RST_BIT 13
`define CW_RST_PIN_BIT 12

`define DATA_AREA_BASE 16'hC000
`define DATA_AREA_TOP 16'hC0FF
`define CODE_AREA_TOP 16'h3FFF
`define BOOT_VECTOR_APP 16'h0000
`define BOOT_VECTOR_BOOT 16'h3800

// unlock opens 13 cycles after the second key, stays open until cycle 23
`define UNLOCK_OPEN_CYCLES 5'd13
`define UNLOCK_CLOSE_CYCLES 5'd23
`define LONG_RESET_MS 44
`define CLK_KHZ 100000
`define LONG_RESET_CYCLES (`LONG_RESET_MS * `CLK_KHZ)
`define NV_OP_CYCLES 8'd16

`endif

//--- verilog/nv_access.v
// protected configuration register, unlock sequencing and nonvolatile access
// assumes one core on a byte-wide register bus; wr/rd strobes are one cycle,
// core honours STALL_OUT; flash array is modelled by internal arrays
`timescale 1ns/100ps
`default_nettype none
`include "nv_access_map.vh"

module nv_access #(
	parameter [31:0] LONG_RESET_CYCLES = `LONG_RESET_CYCLES,
	parameter [7:0] PART_IDENTITY_VALUE = 8'h3C, // arbitrary value
	parameter [1:0] VARIANT_TOP_BITS = 2'b10
) (
	input wire CLK_IN,
	input wire NRST_IN,
	input wire [7:0] SFR_ADDR_IN,
	input wire [7:0] SFR_WDATA_IN,
	input wire SFR_WR_IN,
	input wire SFR_RD_IN,
	output reg [7:0] SFR_RDATA_OUT,
	output wire STALL_OUT,
	input wire WDOG_OVERFLOW_IN,
	input wire RST_PIN_IN,
	input wire [15:0] CONFIG_WORD_IN,
	output wire SYS_RESET_OUT,
	output wire REGULATOR_OFF_OUT,
	output wire READOUT_ALLOWED_OUT,
	output wire [15:0] BOOT_VECTOR_OUT,
	output wire RESET_EXTENDING_OUT,
	output wire UNLOCKED_OUT
);

	// ----------------------------------------------------------------
	// shared decode helpers
	// ----------------------------------------------------------------
	// one register write strobe landing on a given offset
	function write_hit;
		input wr;
		input [7:0] addr;
		input [7:0] target;
		begin
			write_hit = wr && (addr == target);
		end
	endfunction

	// the two commands that start an array operation and stall the core
	function command_known;
		input [7:0] code;
		begin
			case (code)
				`CMD_WRITE: command_known = 1'b1;
				`CMD_READ_DATA: command_known = 1'b1;
				default: command_known = 1'b0;
			endcase
		end
	endfunction

	// data area: even addresses only, everything else is refused
	function data_area_hit;
		input [15:0] addr;
		begin
			data_area_hit = (addr >= `DATA_AREA_BASE) && (addr <= `DATA_AREA_TOP) && !addr[0];
		end
	endfunction

	// code area: word writes need the lowest address bit clear
	function code_area_hit;
		input [15:0] addr;
		begin
			code_area_hit = (addr <= `CODE_AREA_TOP) && !addr[0];
		end
	endfunction

	// byte slot of the data area; odd addresses hold no storage
	function [6:0] data_slot;
		input [15:0] addr;
		begin
			data_slot = addr[7:1];
		end
	endfunction

	// word slot of the code area
	function [12:0] code_slot;
		input [15:0] addr;
		begin
			code_slot = addr[13:1];
		end
	endfunction

	// start address picked by the stored boot select bit
	function [15:0] boot_vector;
		input sel;
		begin
			boot_vector = sel ? `BOOT_VECTOR_BOOT : `BOOT_VECTOR_APP;
		end
	endfunction

	// config register as read: variant bits, boot flag, writable bits
	function [7:0] config_value;
		input [1:0] top;
		input boot;
		input [4:0] bits;
		begin
			config_value = {top, boot, bits};
		end
	endfunction

	// result register as the core reads it; unused bits read zero
	function [7:0] result_value;
		input addr_ok;
		input cmd_fault;
		begin
			result_value = 8'h00;
			result_value[`RES_ADDR_OK_BIT] = addr_ok;
			result_value[`RES_CMD_FAULT_BIT] = cmd_fault;
		end
	endfunction

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	reg [1:0] rst_sync_q;
	reg [1:0] pin_sync_q;
	wire rst_n = rst_sync_q[1];

	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			pin_sync_q <= 2'b00;
		else
			pin_sync_q <= {pin_sync_q[0], RST_PIN_IN};
	end

	// ----------------------------------------------------------------
	// configuration word, caught once after release
	// ----------------------------------------------------------------
	reg cw_taken_q;
	reg [15:0] cw_q;
	reg [31:0] long_cnt_q;

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cw_taken_q <= 1'b0;
			cw_q <= 16'h0000;
		end else if (!cw_taken_q) begin
			cw_taken_q <= 1'b1;
			cw_q <= CONFIG_WORD_IN;
		end
	end

	// power-on stretch reloads on every NRST_IN release, not on a soft reset
	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			long_cnt_q <= 32'h0000_0000;
		else if (!cw_taken_q)
			long_cnt_q <= CONFIG_WORD_IN[`CW_LONG_RST_BIT] ? LONG_RESET_CYCLES : 32'h0000_0000;
		else if (long_cnt_q != 32'h0000_0000)
			long_cnt_q <= long_cnt_q - 32'h0000_0001;
	end

	assign RESET_EXTENDING_OUT = !cw_taken_q || (long_cnt_q != 32'h0000_0000);
	assign READOUT_ALLOWED_OUT = cw_q[`CW_READOUT_BIT];
	assign BOOT_VECTOR_OUT = boot_vector(cw_q[`CW_BOOT_SEL_BIT]);
	wire pin_reset = cw_q[`CW_RST_PIN_BIT] && pin_sync_q[1];

	// ----------------------------------------------------------------
	// unlock sequencer
	// ----------------------------------------------------------------
	localparam [1:0] UL_IDLE = 2'd0;
	localparam [1:0] UL_ARMED = 2'd1;
	localparam [1:0] UL_TIMING = 2'd2;

	reg [1:0] ul_state_q;
	reg [4:0] ul_cnt_q;
	wire wr_unlock = write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_PART_IDENTITY);
	wire unlocked = (ul_state_q == UL_TIMING) && (ul_cnt_q >= `UNLOCK_OPEN_CYCLES);

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ul_state_q <= UL_IDLE;
			ul_cnt_q <= 5'd0;
		end else begin
			case (ul_state_q)
				UL_IDLE: begin
					if (wr_unlock && SFR_WDATA_IN == `UNLOCK_KEY_FIRST)
						ul_state_q <= UL_ARMED;
				end
				UL_ARMED: begin
					// the second key must be the next register write other than a repeated first key
					if (SFR_WR_IN) begin
						ul_cnt_q <= 5'd0;
						if (wr_unlock && SFR_WDATA_IN == `UNLOCK_KEY_SECOND)
							ul_state_q <= UL_TIMING;
						else if (wr_unlock && SFR_WDATA_IN == `UNLOCK_KEY_FIRST)
							ul_state_q <= UL_ARMED;
						else
							ul_state_q <= UL_IDLE;
					end
				end
				UL_TIMING: begin
					if (wr_unlock || ul_cnt_q == `UNLOCK_CLOSE_CYCLES)
						ul_state_q <= UL_IDLE;
					else
						ul_cnt_q <= ul_cnt_q + 5'd1;
				end
				default: ul_state_q <= UL_IDLE;
			endcase
		end
	end

	assign UNLOCKED_OUT = unlocked;

	// ----------------------------------------------------------------
	// system configuration
	// ----------------------------------------------------------------
	reg boot_q;
	reg soft_rst_q;
	reg code_we_q;
	reg data_we_q;
	reg reg_off_q;
	reg wdog_en_q;
	reg [4:0] cfg_bits_d;
	wire wr_cfg = write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_SYSTEM_CONFIG) && unlocked;

	// boot flag lives on the NRST_IN reset only, so a soft reset can clear it
	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			boot_q <= 1'b1;
		else if (soft_rst_q)
			boot_q <= 1'b0;
	end

	// soft reset pulse lasts one cycle; the system reset output carries it
	// a pending soft reset wins over a write in the same cycle
	always @* begin
		cfg_bits_d = {soft_rst_q, code_we_q, data_we_q, reg_off_q, wdog_en_q};
		if (soft_rst_q)
			cfg_bits_d = 5'h00;
		else if (wr_cfg)
			cfg_bits_d = SFR_WDATA_IN[4:0];
	end

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst_q <= 1'b0;
			code_we_q <= 1'b0;
			data_we_q <= 1'b0;
			reg_off_q <= 1'b0;
			wdog_en_q <= 1'b0;
		end else begin
			soft_rst_q <= cfg_bits_d[`CFG_SOFT_RST_BIT];
			code_we_q <= cfg_bits_d[`CFG_CODE_WE_BIT];
			data_we_q <= cfg_bits_d[`CFG_DATA_WE_BIT];
			reg_off_q <= cfg_bits_d[`CFG_REG_OFF_BIT];
			wdog_en_q <= cfg_bits_d[`CFG_WDOG_BIT];
		end
	end

	assign REGULATOR_OFF_OUT = reg_off_q;
	assign SYS_RESET_OUT = soft_rst_q || (wdog_en_q && WDOG_OVERFLOW_IN) || pin_reset;

	wire [7:0] cfg_value = config_value(VARIANT_TOP_BITS, boot_q,
		{soft_rst_q, code_we_q, data_we_q, reg_off_q, wdog_en_q});

	// ----------------------------------------------------------------
	// nonvolatile address, data and command
	// ----------------------------------------------------------------
	reg [7:0] addr_lo_q;
	reg [7:0] addr_hi_q;
	reg [7:0] data_lo_q;
	reg [7:0] data_hi_q;
	reg addr_ok_q;
	reg cmd_fault_q;
	reg [7:0] busy_q;
	// data area: 128 even-address bytes; code area: 8K words
	reg [7:0] data_mem [0:127];
	reg [15:0] code_mem [0:8191];

	wire [15:0] nv_addr = {addr_hi_q, addr_lo_q};
	wire in_data = data_area_hit(nv_addr);
	wire in_code = code_area_hit(nv_addr);
	wire wr_ok = (in_data && (data_we_q || code_we_q)) || (in_code && code_we_q);
	wire wr_cmd = write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_NV_RESULT) && (busy_q == 8'd0);

	assign STALL_OUT = (busy_q != 8'd0);

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			busy_q <= 8'd0;
		else if (wr_cmd && command_known(SFR_WDATA_IN))
			busy_q <= `NV_OP_CYCLES;
		else if (busy_q != 8'd0)
			busy_q <= busy_q - 8'd1;
	end

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			data_hi_q <= 8'h00;
			addr_ok_q <= 1'b0;
			cmd_fault_q <= 1'b0;
		end else begin
			if (write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_NV_ADDRESS_LOW))
				addr_lo_q <= SFR_WDATA_IN;
			if (write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_NV_ADDRESS_HIGH))
				addr_hi_q <= SFR_WDATA_IN;
			if (write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_NV_DATA_HIGH))
				data_hi_q <= SFR_WDATA_IN;
			if (wr_cmd) begin
				case (SFR_WDATA_IN)
					`CMD_WRITE: begin
						cmd_fault_q <= 1'b0;
						addr_ok_q <= wr_ok;
					end
					`CMD_READ_DATA: begin
						cmd_fault_q <= 1'b0;
						addr_ok_q <= in_data;
					end
					default: cmd_fault_q <= 1'b1;
				endcase
			end
		end
	end

	// arrays carry no reset: contents survive any system reset
	always @(posedge CLK_IN) begin
		if (wr_cmd && SFR_WDATA_IN == `CMD_WRITE && wr_ok) begin
			if (in_data)
				data_mem[data_slot(nv_addr)] <= data_lo_q;
			else
				code_mem[code_slot(nv_addr)] <= {data_hi_q, data_lo_q};
		end
	end

	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			data_lo_q <= 8'h00;
		else if (wr_cmd && SFR_WDATA_IN == `CMD_READ_DATA && in_data)
			data_lo_q <= data_mem[data_slot(nv_addr)];
		else if (write_hit(SFR_WR_IN, SFR_ADDR_IN, `ADDR_NV_DATA_LOW))
			data_lo_q <= SFR_WDATA_IN;
	end

	// ----------------------------------------------------------------
	// read mux, registered
	// ----------------------------------------------------------------
	reg [7:0] rdata_d;

	always @* begin
		case (SFR_ADDR_IN)
			`ADDR_NV_ADDRESS_LOW: rdata_d = addr_lo_q;
			`ADDR_NV_ADDRESS_HIGH: rdata_d = addr_hi_q;
			`ADDR_NV_RESULT: rdata_d = result_value(addr_ok_q, cmd_fault_q);
			`ADDR_NV_DATA_LOW: rdata_d = data_lo_q;
			`ADDR_NV_DATA_HIGH: rdata_d = data_hi_q;
			`ADDR_SYSTEM_CONFIG: rdata_d = cfg_value;
			`ADDR_PART_IDENTITY: rdata_d = PART_IDENTITY_VALUE;
			default: rdata_d = 8'h00;
		endcase
	end

	// read data holds until the next read strobe
	always @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			SFR_RDATA_OUT <= 8'h00;
		else if (SFR_RD_IN)
			SFR_RDATA_OUT <= rdata_d;
	end

endmodule // nv_access
`default_nettype wire

//--- test/nv_access_monitor.sv
// assertions on the port behaviour of nv_access
// assumes bind into nv_access, one clock domain
`timescale 1ns/100ps
`default_nettype none
module nv_access_monitor #(
	parameter [7:0] PART_IDENTITY_VALUE = 8'h3C
) (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic [7:0] SFR_ADDR_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	input wire logic SFR_WR_IN,
	input wire logic SFR_RD_IN,
	input wire logic [7:0] SFR_RDATA_OUT,
	input wire logic STALL_OUT,
	input wire logic SYS_RESET_OUT,
	input wire logic REGULATOR_OFF_OUT,
	input wire logic [15:0] BOOT_VECTOR_OUT,
	input wire logic UNLOCKED_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	wire wr_key = SFR_WR_IN && SFR_ADDR_IN == 8'hA1;
	wire wr_cfg = SFR_WR_IN && SFR_ADDR_IN == 8'hB1;
	// window too long for a repeat, so count it
	reg [4:0] open_q;
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			open_q <= 5'h00;
		else if (UNLOCKED_OUT)
			open_q <= open_q + 5'h01;
		else
			open_q <= 5'h00;
	end
	sequence s_key;
		wr_key && SFR_WDATA_IN == 8'h55 ##2 wr_key && SFR_WDATA_IN == 8'hAA;
	endsequence
	sequence s_cmd;
		SFR_WR_IN && SFR_ADDR_IN == 8'h86 && !STALL_OUT && (SFR_WDATA_IN == 8'h9A || SFR_WDATA_IN == 8'h8E);
	endsequence
	AST_UNLOCK_OPEN: assert property (s_key |=> !UNLOCKED_OUT [*8] ##[4:7] UNLOCKED_OUT)
		else $error("unlock window opened off time");
	AST_UNLOCK_SPAN: assert property (open_q <= 5'h0B)
		else $error("unlock window too long");
	AST_UNLOCK_ABORT: assert property (UNLOCKED_OUT && wr_key |=> !UNLOCKED_OUT)
		else $error("unlock not ended by key write");
	AST_LOCKED_IGNORE: assert property (wr_cfg && !UNLOCKED_OUT |=> $stable(REGULATOR_OFF_OUT) [*2])
		else $error("locked config write took effect");
	AST_REG_OFF: assert property (wr_cfg && UNLOCKED_OUT && SFR_WDATA_IN[1] && !SFR_WDATA_IN[4]
		|-> ##[1:2] REGULATOR_OFF_OUT)
		else $error("regulator disable not applied");
	AST_SOFT_RST: assert property (wr_cfg && UNLOCKED_OUT && SFR_WDATA_IN[4] |-> ##[0:2] SYS_RESET_OUT)
		else $error("soft reset not raised");
	AST_ID_READ: assert property (SFR_RD_IN && SFR_ADDR_IN == 8'hA1 |=> SFR_RDATA_OUT == PART_IDENTITY_VALUE)
		else $error("identity read wrong");
	AST_STALL_START: assert property (s_cmd |=> STALL_OUT)
		else $error("command did not stall");
	AST_STALL_LEN: assert property ($rose(STALL_OUT) |-> STALL_OUT [*8] ##1 STALL_OUT [*8] ##1 !STALL_OUT)
		else $error("stall length wrong");
	AST_BOOT_VEC: assert property (BOOT_VECTOR_OUT == 16'h0000 || BOOT_VECTOR_OUT == 16'h3800)
		else $error("boot vector not a legal start");
endmodule // nv_access_monitor
bind nv_access nv_access_monitor #(.PART_IDENTITY_VALUE(PART_IDENTITY_VALUE)) nv_access_monitor_inst (
	.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
	.SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT), .STALL_OUT(STALL_OUT),
	.SYS_RESET_OUT(SYS_RESET_OUT), .REGULATOR_OFF_OUT(REGULATOR_OFF_OUT),
	.BOOT_VECTOR_OUT(BOOT_VECTOR_OUT), .UNLOCKED_OUT(UNLOCKED_OUT));
`default_nettype wire

//--- test/core_model.sv
// processor core model on the register bus of nv_access
// assumes one-cycle strobes; waits out a running flash command
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input wire logic clk_in,
	input wire logic stall_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// core is frozen while a command runs
	task automatic idle_wait;
		@(posedge clk_in);
		#1;
		while (stall_in) begin
			@(posedge clk_in);
			#1;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		idle_wait();
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1 wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		idle_wait();
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1 rd_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
	endtask
	task automatic unlock;
		wr(8'hA1, 8'h55);
		wr(8'hA1, 8'hAA);
	endtask
endmodule // core_model
`default_nettype wire

//--- test/nv_access_tb_top.sv
// self-checking bench for nv_access driven by the core model
// assumes 100 MHz clock and a shortened long-reset count
`timescale 1ns/100ps
`default_nettype none
module nv_access_tb_top;
	localparam logic [7:0] ID = 8'h5A; // arbitrary value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wdog = 1'b0;
	logic pin = 1'b0;
	logic [15:0] cw = 16'h0000;
	wire [7:0] addr, wdata, rdata;
	wire wr, rd, stall, sys_rst, reg_off, readout, rst_ext, unlocked;
	wire [15:0] boot;
	logic [7:0] d, v;
	logic [15:0] a;
	int mismatches = 0;
	int checks = 0;
	int mem [128];
	always #5 clk = ~clk;
	nv_access #(.LONG_RESET_CYCLES(32'h0000_0014), .PART_IDENTITY_VALUE(ID)) nv_access_inst (
		.CLK_IN(clk), .NRST_IN(rst_n), .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wdata), .SFR_WR_IN(wr),
		.SFR_RD_IN(rd), .SFR_RDATA_OUT(rdata), .STALL_OUT(stall), .WDOG_OVERFLOW_IN(wdog),
		.RST_PIN_IN(pin), .CONFIG_WORD_IN(cw), .SYS_RESET_OUT(sys_rst), .REGULATOR_OFF_OUT(reg_off),
		.READOUT_ALLOWED_OUT(readout), .BOOT_VECTOR_OUT(boot), .RESET_EXTENDING_OUT(rst_ext),
		.UNLOCKED_OUT(unlocked));
	core_model core_model_inst (.clk_in(clk), .stall_in(stall), .rdata_in(rdata),
		.addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic rdc(input logic [7:0] ra, input logic [7:0] exp);
		core_model_inst.rd(ra, d);
		chk("register", d, exp);
	endtask
	task automatic op(input logic [7:0] dt, input logic [7:0] c);
		core_model_inst.wr(8'h84, a[7:0]);
		core_model_inst.wr(8'h85, a[15:8]);
		core_model_inst.wr(8'h8E, dt);
		core_model_inst.wr(8'h86, c);
	endtask
	task automatic open_cfg(input logic [7:0] val);
		core_model_inst.unlock();
		repeat (14) @(posedge clk);
		#1 chk("unlocked", unlocked, 1'b1);
		if (val != 8'hFF)
			core_model_inst.wr(8'hB1, val);
	endtask
	task automatic pulse(input logic exp);
		@(posedge clk);
		#1 wdog = 1'b1;
		#1 chk("sys reset", sys_rst, exp);
		@(posedge clk);
		#1 wdog = 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
	// ----
	// main sequence
	// ----
	initial begin
		cw = 16'($urandom(32'hea49e35a));
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("reset after release", sys_rst, 1'b0);
		repeat (7) @(posedge clk);
		#1 chk("extend", rst_ext, cw[13]);
		chk("readout", readout, cw[15]);
		chk("boot", boot, cw[14] ? 16'h3800 : 16'h0000);
		rdc(8'hB1, 8'hA0);
		core_model_inst.wr(8'hA1, 8'h00);
		rdc(8'hA1, ID);
		rdc(8'h86, 8'h00);
		rdc(8'h30, 8'h00);
		core_model_inst.wr(8'hB1, 8'h0E);
		rdc(8'hB1, 8'hA0);
		pulse(1'b0);
		open_cfg(8'h04);
		rdc(8'hB1, 8'hA4);
		for (int i = 0; i < 4; i++) begin
			a = {8'hC0, 7'($urandom), 1'b0};
			v = 8'($urandom);
			op(v, 8'h9A);
			mem[a[7:1]] = v;
			rdc(8'h86, 8'h40);
			op(~v, 8'h8E);
			rdc(8'h8E, 8'(mem[a[7:1]]));
		end
		op(v, 8'h11);
		rdc(8'h86, 8'h42);
		open_cfg(8'h00);
		op(~v, 8'h9A);
		op(v, 8'h8E);
		rdc(8'h8E, 8'(mem[a[7:1]]));
		open_cfg(8'h08);
		op(~v, 8'h9A);
		mem[a[7:1]] = ~v;
		op(v, 8'h8E);
		rdc(8'h8E, 8'(mem[a[7:1]]));
		a = 16'h0100;
		core_model_inst.wr(8'h8F, ~v);
		op(v, 8'h9A);
		rdc(8'h86, 8'h40);
		op(v, 8'h8E);
		rdc(8'h86, 8'h00);
		open_cfg(8'hFF);
		core_model_inst.wr(8'hA1, 8'h00);
		chk("abort", unlocked, 1'b0);
		open_cfg(8'h12);
		repeat (20) @(posedge clk);
		#1 chk("timeout", unlocked, 1'b0);
		rdc(8'hB1, 8'h80);
		open_cfg(8'h03);
		repeat (2) @(posedge clk);
		#1 chk("regulator", reg_off, 1'b1);
		pulse(1'b1);
		pin = 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("pin reset", sys_rst, cw[12]);
		pin = 1'b0;
		chk("extend end", rst_ext, 1'b0);
		print_verdict();
	end
endmodule // nv_access_tb_top
`default_nettype wire
